// ===== core/rsw_consts.vh
// constants and rule summary for the reset source and watchdog control block
// Rules for this block and the software using it
// RL1 - two config bits pick low-voltage threshold
// RL2 - code 37h disables low-voltage and power-on detect
// RL3 - code 38h disables low-voltage detect only
// RL4 - disable works in fast mode; register write-only
// RL5 - power-save bit alters idle/stop low-voltage behaviour
// RL6 - five sources; each restores register defaults
// RL7 - power-on: 25 ms warm-up, then config load
// RL8 - external pin low two slow clocks resets
// RL9 - external pin honoured only when config bit6 set
// RL10 - writing 56h to 97h resets device
// RL11 - watchdog counts slow clock; idle/stop per enable
// RL12 - period field selects 400/200/100/50 ms
// RL13 - control 0x off, 10 run modes, 11 always
// RL14 - enabled watchdog overflow issues reset
// RL15 - watchdog cleared by reset or clear bit
// RL16 - clear bit self-clears next cycle
// RL17 - software keeps low-voltage reset on, right level
// RL18 - after any reset run slow clock mode
// RL19 - sources ORed; held until released and loaded
// RL20 - pin synchronised and filtered on slow clock
`ifndef RSW_CONSTS_VH
`define RSW_CONSTS_VH
// register offsets
`define RSW_ADDR_OPTION 13'h0094
`define RSW_ADDR_SOFTWARE_COMMAND 13'h0097
`define RSW_ADDR_SUPPD 13'h00E5
`define RSW_ADDR_AUXILIARY_CONTROL_TWO 13'h00F7
`define RSW_ADDR_AUXILIARY_CONTROL_ONE 13'h00F8
`define RSW_ADDR_CONFIG_WORD_HIGH 13'h1FFF
`define RSW_ADDR_CFGBASE 13'h1FF0
// reset values
`define RSW_RST_OPTION 8'h00
`define RSW_RST_AUXILIARY_CONTROL_TWO 8'h06
`define RSW_RST_AUXILIARY_CONTROL_ONE 8'h00
`define RSW_RST_CONFIG_WORD_HIGH 8'h00
// command codes
`define RSW_CODE_ALLOFF 8'h37
`define RSW_CODE_LVOFF 8'h38
`define RSW_CODE_SOFTWARE_RESET_COMMAND 8'h56
// field positions
`define RSW_CFG_XEN 6
`define RSW_CFG_LV_HI 5
`define RSW_CFG_LV_LO 4
`define RSW_OPT_PS_HI 5
`define RSW_OPT_PS_LO 4
`define RSW_AUXILIARY_CONTROL_TWO_WC_HI 7
`define RSW_AUXILIARY_CONTROL_TWO_WC_LO 6
`define RSW_AUXILIARY_CONTROL_TWO_PSAV 5
`define RSW_AUXILIARY_CONTROL_ONE_CLR 7
`define RSW_AUXILIARY_CONTROL_ONE_MASK 8'h5D
// timing
`define RSW_CLK_HZ 250000000
`define RSW_SRC_HZ 80000
`define RSW_SRC_DIV (`RSW_CLK_HZ / `RSW_SRC_HZ)
`define RSW_WARM_MS 25
`define RSW_WARM_TICKS (`RSW_WARM_MS * `RSW_SRC_HZ / 1000)
`define RSW_WDT_MS 400
`define RSW_WDT_TICKS (`RSW_WDT_MS * `RSW_SRC_HZ / 1000)
`define RSW_PIN_MIN 2
`define RSW_CFG_BYTES 16
`endif

// ===== core/rsw_ctrl.v
// reset source combining, supervisor controls and watchdog
`timescale 1ns/1ps
`default_nettype none
`include "rsw_consts.vh"
module rsw_ctrl #(
  parameter integer SRC_DIV = `RSW_SRC_DIV,
  parameter integer WARM_TICKS = `RSW_WARM_TICKS,
  parameter integer WDT_TICKS = `RSW_WDT_TICKS
) (
  // clock and power-on reset
  input wire clk_sys,
  input wire rst_b,
  // register port
  input wire [12:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // analog detectors and pin
  input wire por_detect,
  input wire low_voltage_detect,
  input wire external_pin_reset_b,
  // operating mode from clock block
  input wire fast_mode,
  input wire idle_stop_mode,
  // config word load from flash
  output reg cfg_rd_req,
  output reg [12:0] cfg_rd_addr,
  input wire [7:0] cfg_rd_data,
  input wire cfg_rd_valid,
  // outputs to the chip
  output reg sys_reset_b,
  output reg force_slow_clock,
  output reg low_voltage_reset_en,
  output reg por_detect_en,
  output reg [1:0] low_voltage_threshold_select,
  output reg power_save
);

  ////////////////////////////////////////////////////////////////
  localparam [1:0] ST_WARM = 2'd0;
  localparam [1:0] ST_LOAD = 2'd1;
  localparam [1:0] ST_RUN = 2'd2;
  localparam [1:0] ST_HOLD = 2'd3;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [11:0] div_q;
  reg tick_q;
  reg [15:0] warm_q;
  reg [3:0] idx_q;
  reg busy_q;
  reg [7:0] cfg_q;
  reg [7:0] option_q;
  reg [7:0] auxiliary_control_two_q;
  reg [7:0] auxiliary_control_one_q;
  reg clr_q;
  reg lv_off_q;
  reg por_off_q;
  reg sw_req_q;
  reg wdt_req_q;
  reg [15:0] wdt_q;
  reg [1:0] pin_low_q;
  reg ext_seen_q;
  wire pin_s;
  wire por_s;
  wire lv_s;
  wire running;
  wire wr_ok;
  wire por_req;
  wire lv_req;
  wire ext_req;
  wire any_req;
  wire lv_mute;
  reg wdt_run;
  reg wdt_armed;
  reg [15:0] wdt_lim;
  wire last_byte;
  localparam integer PIN_MIN = `RSW_PIN_MIN;
  localparam integer CFG_LAST = `RSW_CFG_BYTES - 1;

  ////////////////////////////////////////////////////////////////
  // two-stage synchronisers for pin and detectors
  wire [2:0] async_in;
  wire [2:0] sync_out;
  assign async_in = {external_pin_reset_b, por_detect, low_voltage_detect};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          s1_q <= (gi == 2) ? 1'b1 : 1'b0;
          s2_q <= (gi == 2) ? 1'b1 : 1'b0;
        end else begin
          s1_q <= async_in[gi];
          s2_q <= s1_q;
        end
      end
      assign sync_out[gi] = s2_q;
    end
  endgenerate
  assign pin_s = sync_out[2];
  assign por_s = sync_out[1];
  assign lv_s = sync_out[0];

  ////////////////////////////////////////////////////////////////
  // slow clock tick divider
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 12'h000;
      tick_q <= 1'b0;
    end else if (div_q == SRC_DIV[11:0] - 12'h001) begin
      div_q <= 12'h000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 12'h001;
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // reset sources
  assign running = (state_q == ST_RUN);
  assign wr_ok = reg_wr && running;
  assign por_req = por_s && !por_off_q; // [RL2]
  // power-save mutes the detector in idle/stop
  assign lv_mute = power_save && idle_stop_mode; // [RL5]
  assign lv_req = lv_s && !lv_off_q && !lv_mute;
  assign ext_req = cfg_q[`RSW_CFG_XEN] && (pin_low_q == PIN_MIN[1:0]); // [RL9]
  assign any_req = ext_req || ext_seen_q || lv_req || sw_req_q || wdt_req_q; // [RL6] [RL19]
  assign last_byte = (idx_q == CFG_LAST[3:0]);

  // pin sampled on slow tick, two low samples needed
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_low_q <= 2'd0;
    end else if (pin_s) begin
      pin_low_q <= 2'd0;
    end else if (tick_q && pin_low_q != PIN_MIN[1:0]) begin
      pin_low_q <= pin_low_q + 2'd1; // [RL8] [RL20]
    end
  end

  // short qualified pulse kept until the sequencer holds
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ext_seen_q <= 1'b0;
    end else if (ext_req) begin
      ext_seen_q <= 1'b1; // [RL8]
    end else if (state_q == ST_HOLD || por_req) begin
      ext_seen_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // reset sequencer
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_WARM: begin
        if (tick_q && warm_q == WARM_TICKS[15:0] - 16'h0001) begin
          state_d = ST_LOAD; // [RL7]
        end
      end
      ST_LOAD: begin
        if (busy_q && cfg_rd_valid && last_byte) begin
          state_d = any_req ? ST_HOLD : ST_RUN; // [RL19]
        end
      end
      ST_RUN: begin
        if (any_req) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!any_req) begin
          state_d = ST_LOAD;
        end
      end
      default: begin
        state_d = ST_WARM;
      end
    endcase
    if (por_req) begin
      state_d = ST_WARM;
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_WARM;
      warm_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      if (state_q != ST_WARM || por_req) begin
        warm_q <= 16'h0000;
      end else if (tick_q) begin
        warm_q <= warm_q + 16'h0001; // [RL7]
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // config word load, last sixteen flash bytes
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      idx_q <= 4'h0;
      busy_q <= 1'b0;
      cfg_rd_req <= 1'b0;
      cfg_rd_addr <= `RSW_ADDR_CFGBASE;
      cfg_q <= `RSW_RST_CONFIG_WORD_HIGH;
    end else if (state_q != ST_LOAD || por_req) begin
      idx_q <= 4'h0;
      busy_q <= 1'b0;
      cfg_rd_req <= 1'b0;
      cfg_rd_addr <= `RSW_ADDR_CFGBASE;
    end else begin
      cfg_rd_req <= 1'b0;
      if (!busy_q) begin
        busy_q <= 1'b1;
        cfg_rd_req <= 1'b1;
        cfg_rd_addr <= `RSW_ADDR_CFGBASE + {9'h000, idx_q};
      end else if (cfg_rd_valid) begin
        busy_q <= 1'b0;
        idx_q <= idx_q + 4'h1;
        if (last_byte) begin
          cfg_q <= cfg_rd_data; // [RL7]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // software registers, back to defaults outside run [RL6]
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      option_q <= `RSW_RST_OPTION;
      auxiliary_control_two_q <= `RSW_RST_AUXILIARY_CONTROL_TWO;
      auxiliary_control_one_q <= `RSW_RST_AUXILIARY_CONTROL_ONE;
      clr_q <= 1'b0;
      lv_off_q <= 1'b0;
      por_off_q <= 1'b0;
      sw_req_q <= 1'b0;
    end else if (!running) begin
      option_q <= `RSW_RST_OPTION;
      auxiliary_control_two_q <= `RSW_RST_AUXILIARY_CONTROL_TWO;
      auxiliary_control_one_q <= `RSW_RST_AUXILIARY_CONTROL_ONE;
      clr_q <= 1'b0;
      lv_off_q <= 1'b0;
      por_off_q <= 1'b0;
      sw_req_q <= 1'b0;
    end else begin
      clr_q <= 1'b0; // [RL16]
      sw_req_q <= 1'b0;
      if (wr_ok) begin
        case (reg_addr)
          `RSW_ADDR_OPTION: option_q <= reg_wdata;
          `RSW_ADDR_AUXILIARY_CONTROL_TWO: auxiliary_control_two_q <= reg_wdata;
          `RSW_ADDR_AUXILIARY_CONTROL_ONE: begin
            auxiliary_control_one_q <= reg_wdata & `RSW_AUXILIARY_CONTROL_ONE_MASK;
            clr_q <= reg_wdata[`RSW_AUXILIARY_CONTROL_ONE_CLR];
          end
          `RSW_ADDR_SOFTWARE_COMMAND: sw_req_q <= (reg_wdata == `RSW_CODE_SOFTWARE_RESET_COMMAND); // [RL10]
          `RSW_ADDR_SUPPD: begin
            if (fast_mode) begin // [RL4]
              case (reg_wdata)
                `RSW_CODE_ALLOFF: begin
                  lv_off_q <= 1'b1; // [RL2]
                  por_off_q <= 1'b1;
                end
                `RSW_CODE_LVOFF: begin
                  lv_off_q <= 1'b1; // [RL3]
                  por_off_q <= 1'b0;
                end
                default: begin
                end
              endcase
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // read data one cycle after strobe; write-only and unmapped read 0
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `RSW_ADDR_OPTION: reg_rdata <= option_q;
        `RSW_ADDR_AUXILIARY_CONTROL_TWO: reg_rdata <= auxiliary_control_two_q;
        `RSW_ADDR_AUXILIARY_CONTROL_ONE: reg_rdata <= auxiliary_control_one_q | {clr_q, 7'h00};
        `RSW_ADDR_CONFIG_WORD_HIGH: reg_rdata <= cfg_q;
        default: reg_rdata <= 8'h00; // [RL4]
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////
  // watchdog on the slow tick
  // period halves with each step of the field
  always @* begin
    case (option_q[`RSW_OPT_PS_HI:`RSW_OPT_PS_LO])
      2'b00: wdt_lim = WDT_TICKS[15:0]; // [RL12]
      2'b01: wdt_lim = WDT_TICKS[16:1];
      2'b10: wdt_lim = WDT_TICKS[17:2];
      2'b11: wdt_lim = WDT_TICKS[18:3];
      default: wdt_lim = WDT_TICKS[15:0];
    endcase
  end

  // control: 0x off, 10 run modes only, 11 every mode
  always @* begin
    case (auxiliary_control_two_q[`RSW_AUXILIARY_CONTROL_TWO_WC_HI:`RSW_AUXILIARY_CONTROL_TWO_WC_LO])
      2'b10: begin
        wdt_run = !idle_stop_mode; // [RL11]
        wdt_armed = !idle_stop_mode; // [RL13]
      end
      2'b11: begin
        wdt_run = 1'b1;
        wdt_armed = 1'b1; // [RL13]
      end
      default: begin
        wdt_run = !idle_stop_mode;
        wdt_armed = 1'b0; // [RL13]
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wdt_q <= 16'h0000;
      wdt_req_q <= 1'b0;
    end else if (!running || clr_q) begin
      wdt_q <= 16'h0000; // [RL15]
      wdt_req_q <= 1'b0;
    end else begin
      wdt_req_q <= 1'b0;
      if (tick_q && wdt_run) begin
        if (wdt_q >= wdt_lim - 16'h0001) begin
          wdt_q <= 16'h0000;
          wdt_req_q <= wdt_armed; // [RL14]
        end else begin
          wdt_q <= wdt_q + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sys_reset_b <= 1'b0;
      force_slow_clock <= 1'b1;
      low_voltage_reset_en <= 1'b1;
      por_detect_en <= 1'b1;
      low_voltage_threshold_select <= 2'b00;
      power_save <= 1'b0;
    end else begin
      sys_reset_b <= (state_d == ST_RUN); // [RL19]
      force_slow_clock <= (state_d != ST_RUN); // [RL18]
      low_voltage_reset_en <= !lv_off_q && !lv_mute; // [RL5]
      por_detect_en <= !por_off_q;
      low_voltage_threshold_select <= cfg_q[`RSW_CFG_LV_HI:`RSW_CFG_LV_LO]; // [RL1]
      power_save <= auxiliary_control_two_q[`RSW_AUXILIARY_CONTROL_TWO_PSAV]; // [RL5]
    end
  end

endmodule // rsw_ctrl
`default_nettype wire

// ===== bench/rsw_ctrl_props.sv
// port assertions for the reset and watchdog controller
`timescale 1ns/1ps
`default_nettype none
module rsw_ctrl_props #(
  parameter integer SRC_DIV = 4,
  parameter integer WARM_TICKS = 3,
  parameter integer WDT_TICKS = 64
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic [12:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // mode and outputs
  input wire logic fast_mode,
  input wire logic cfg_rd_req,
  input wire logic sys_reset_b,
  input wire logic force_slow_clock,
  input wire logic low_voltage_reset_en,
  input wire logic por_detect_en,
  input wire logic power_save
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire logic sup_wr = reg_wr && sys_reset_b && fast_mode && reg_addr == 13'h00E5;
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_sw_cmd_reset: assert property ((reg_wr && sys_reset_b && reg_addr == 13'h0097 && reg_wdata == 8'h56)
    |-> ##2 !sys_reset_b) else $error("software command gave no reset");
  a_reset_slow_clk: assert property (!sys_reset_b |-> force_slow_clock)
    else $error("slow clock not forced in reset");
  a_run_det_on: assert property ($rose(sys_reset_b) |-> low_voltage_reset_en && por_detect_en)
    else $error("detectors not enabled after reset");
  a_run_psave_off: assert property ($rose(sys_reset_b) |-> !power_save)
    else $error("power save not cleared by reset");
  a_code_lv_off: assert property (sup_wr && reg_wdata == 8'h38 |-> ##[1:2] (!low_voltage_reset_en && por_detect_en))
    else $error("code 38 mishandled");
  a_code_all_off: assert property (sup_wr && reg_wdata == 8'h37 |-> ##[1:2] (!low_voltage_reset_en && !por_detect_en))
    else $error("code 37 mishandled");
  a_load_in_reset: assert property (cfg_rd_req |-> !sys_reset_b)
    else $error("config load outside reset");
endmodule // rsw_ctrl_props
bind rsw_ctrl rsw_ctrl_props #(.SRC_DIV(SRC_DIV), .WARM_TICKS(WARM_TICKS), .WDT_TICKS(WDT_TICKS)) i_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fast_mode(fast_mode), .cfg_rd_req(cfg_rd_req),
  .sys_reset_b(sys_reset_b), .force_slow_clock(force_slow_clock), .low_voltage_reset_en(low_voltage_reset_en),
  .por_detect_en(por_detect_en), .power_save(power_save));
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the reset and watchdog controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'h0;
  logic rst_b = 1'h0;
  logic [12:0] reg_addr = 13'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0, reg_rd = 1'h0, por_detect = 1'h0, low_voltage_detect = 1'h0;
  logic external_pin_reset_b = 1'h1, fast_mode = 1'h0, idle_stop_mode = 1'h0, cfg_rd_valid = 1'h0;
  logic [7:0] cfg_rd_data = 8'h00;
  logic [7:0] cfg_byte = 8'h70;
  wire [7:0] reg_rdata;
  wire [12:0] cfg_rd_addr;
  wire [1:0] low_voltage_threshold_select;
  wire cfg_rd_req, sys_reset_b, force_slow_clock, low_voltage_reset_en, por_detect_en, power_save;
  int n_fail = 0;
  int compares = 0;
  rsw_ctrl #(.SRC_DIV(4), .WARM_TICKS(3), .WDT_TICKS(64)) i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .por_detect(por_detect), .low_voltage_detect(low_voltage_detect),
    .external_pin_reset_b(external_pin_reset_b), .fast_mode(fast_mode), .idle_stop_mode(idle_stop_mode),
    .cfg_rd_req(cfg_rd_req), .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data), .cfg_rd_valid(cfg_rd_valid),
    .sys_reset_b(sys_reset_b), .force_slow_clock(force_slow_clock), .low_voltage_reset_en(low_voltage_reset_en),
    .por_detect_en(por_detect_en), .low_voltage_threshold_select(low_voltage_threshold_select),
    .power_save(power_save));
  initial forever #2 clk_sys = ~clk_sys;
  // flash answers one cycle after each request
  always @(posedge clk_sys) begin
    cfg_rd_valid <= cfg_rd_req;
    cfg_rd_data <= (cfg_rd_addr == 13'h1FFF) ? cfg_byte : 8'hA5;
  end
  ////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bit1(input string name, input logic exp, input logic got);
    check(name, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 check("reg_rdata", exp, reg_rdata);
  endtask
  task automatic wait_run();
    for (int i = 0; i < 300 && sys_reset_b !== 1'h1; i++) @(posedge clk_sys);
    bit1("sys_reset_b", 1'h1, sys_reset_b);
    @(posedge clk_sys);
  endtask
  task automatic wait_rst(input logic exp, input int n);
    logic seen;
    seen = 1'h0;
    repeat (n) begin
      @(posedge clk_sys);
      if (sys_reset_b === 1'h0) seen = 1'h1;
    end
    bit1("reset seen", exp, seen);
    wait_run();
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'h1;
    wait_run();
    rd(13'h00F7, 8'h06);
    rd(13'h0094, 8'h00);
    rd(13'h00F8, 8'h00);
    rd(13'h00E5, 8'h00);
    rd(13'h0100, 8'h00);
    check("threshold", 8'h03, {6'h00, low_voltage_threshold_select});
    $display("test 1 done");
    wr(13'h0094, 8'h30);
    rd(13'h0094, 8'h30);
    wr(13'h00F8, 8'h80);
    rd(13'h00F8, 8'h80);
    rd(13'h00F8, 8'h00);
    wr(13'h00F7, 8'h26);
    rd(13'h00F7, 8'h26);
    bit1("power_save", 1'h1, power_save);
    idle_stop_mode <= 1'h1;
    repeat (3) @(posedge clk_sys);
    bit1("lv_en", 1'h0, low_voltage_reset_en);
    idle_stop_mode <= 1'h0;
    $display("test 2 done");
    fast_mode <= 1'h1;
    wr(13'h00E5, 8'h38);
    repeat (2) @(posedge clk_sys);
    bit1("lv_en", 1'h0, low_voltage_reset_en);
    bit1("por_en", 1'h1, por_detect_en);
    wr(13'h00E5, 8'h37);
    repeat (2) @(posedge clk_sys);
    bit1("lv_en", 1'h0, low_voltage_reset_en);
    bit1("por_en", 1'h0, por_detect_en);
    wr(13'h0097, 8'h56);
    wait_rst(1'h1, 8);
    bit1("lv_en", 1'h1, low_voltage_reset_en);
    bit1("por_en", 1'h1, por_detect_en);
    rd(13'h0094, 8'h00);
    fast_mode <= 1'h0;
    wr(13'h00E5, 8'h38);
    repeat (2) @(posedge clk_sys);
    bit1("lv_en", 1'h1, low_voltage_reset_en);
    $display("test 3 done");
    wr(13'h00F8, 8'h80);
    wr(13'h0094, 8'h30);
    wr(13'h00F7, 8'hC6);
    wait_rst(1'h0, 20);
    wait_rst(1'h1, 30);
    wait_rst(1'h0, 300);
    idle_stop_mode <= 1'h1;
    wr(13'h00F8, 8'h80);
    wr(13'h0094, 8'h30);
    wr(13'h00F7, 8'h86);
    wait_rst(1'h0, 100);
    idle_stop_mode <= 1'h0;
    wait_rst(1'h1, 60);
    wr(13'h00F8, 8'h80);
    wr(13'h0094, 8'h30);
    wr(13'h00F7, 8'hC6);
    for (int k = 0; k < 6; k++) begin
      wait_rst(1'h0, 20);
      wr(13'h00F8, 8'h80);
    end
    wait_rst(1'h1, 60);
    $display("test 4 done");
    external_pin_reset_b <= 1'h0;
    @(posedge clk_sys);
    external_pin_reset_b <= 1'h1;
    wait_rst(1'h0, 40);
    external_pin_reset_b <= 1'h0;
    repeat (24) @(posedge clk_sys);
    external_pin_reset_b <= 1'h1;
    wait_rst(1'h1, 20);
    external_pin_reset_b <= 1'h0;
    repeat (8) @(posedge clk_sys);
    external_pin_reset_b <= 1'h1;
    wait_rst(1'h1, 20);
    cfg_byte <= 8'h20;
    wr(13'h0097, 8'h56);
    wait_rst(1'h1, 8);
    check("threshold", 8'h02, {6'h00, low_voltage_threshold_select});
    external_pin_reset_b <= 1'h0;
    wait_rst(1'h0, 40);
    external_pin_reset_b <= 1'h1;
    $display("test 5 done");
    low_voltage_detect <= 1'h1;
    repeat (10) @(posedge clk_sys);
    bit1("sys_reset_b", 1'h0, sys_reset_b);
    bit1("slow_clock", 1'h1, force_slow_clock);
    low_voltage_detect <= 1'h0;
    wait_run();
    wr(13'h00F7, 8'h26);
    idle_stop_mode <= 1'h1;
    low_voltage_detect <= 1'h1;
    wait_rst(1'h0, 20);
    low_voltage_detect <= 1'h0;
    repeat (3) @(posedge clk_sys);
    idle_stop_mode <= 1'h0;
    por_detect <= 1'h1;
    repeat (4) @(posedge clk_sys);
    por_detect <= 1'h0;
    wait_rst(1'h1, 10);
    rd(13'h00F7, 8'h06);
    $display("test 6 done");
    complete_run();
  end
endmodule // testbench
`default_nettype wire
